/* File: rtl/dai_defines.vh */
`ifndef DAI_DEFINES_VH
`define DAI_DEFINES_VH
// Register byte offsets
`define DAI_CTRL_ADR 8'h00
`define DAI_STAT_ADR 8'h04
`define DAI_TXD_ADR 8'h08
`define DAI_RXD_ADR 8'h0C
// Control register fields
`define DAI_C_EN 0
`define DAI_C_FMT 1
`define DAI_C_RATE 2
`define DAI_C_BSEL_LO 3
`define DAI_C_BSEL_HI 5
`define DAI_C_CLKMODE 6
`define DAI_C_MCLK 7
`define DAI_C_PAD 8
`define DAI_C_W 9
`define DAI_CTRL_RST 9'h000
// Status register fields
`define DAI_S_TXRDY 0
`define DAI_S_RXV 1
`define DAI_S_UNDR 2
`define DAI_S_CERR 3
`define DAI_S_RUN 4
`define DAI_S_SLEEP 5
// Bit clock select codes
`define DAI_B256 3'h0
`define DAI_B512 3'h1
`define DAI_B1024 3'h2
`define DAI_B2048 3'h3
`define DAI_B4096 3'h4
// Bit clock rates in kHz
`define DAI_F256_KHZ 64'd256
`define DAI_F512_KHZ 64'd512
`define DAI_F1024_KHZ 64'd1024
`define DAI_F2048_KHZ 64'd2048
`define DAI_F4096_KHZ 64'd4096
// Sample rates in kHz
`define DAI_FS16_KHZ 64'd16
`define DAI_FS8_KHZ 64'd8
// System clock rate in Hz
`define DAI_CLK_HZ 64'd10000000
// Word length, oscillator width, buffer depth
`define DAI_WORD_BITS 16
`define DAI_NCO_W 24
`define DAI_FIFO_DEPTH 4
`endif

/* File: rtl/sample_fifo.v */
`timescale 1ns/1ps
// Small flip-flop FIFO with valid/ready on both sides
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wr_reg; // Write index
  reg [AW-1:0] rd_reg; // Read index
  reg [AW:0] cnt_reg; // Fill level
  wire push;
  wire pop;

  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Storage write, no reset needed
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  // Pointers and level
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : rd_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // sample_fifo

/* File: rtl/digital_audio_master_port.v */
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "dai_defines.vh"
// Operation
// - Port runs either PCM or I2S format
// - PCM mode drives frame sync as master
// - PCM frames at 16 kHz or 8 kHz, set by the rate bit
// - Bus frame rate independent of call bandwidth
// - PCM 16 kHz: 256/512/1024/4096 kHz clock
// - PCM 8 kHz: 256/512/2048 kHz clock
// - Data leaves on output, returns on input
// - Continuous clock mode forbids low-power sleep
// - Switchable master clock synchronous to bit clock
// - Samples are 16-bit two's complement words
// - PCM drives on rising edge, samples on falling; I2S the reverse
// - I2S carries mono voice both directions
// - I2S mode generates the bit clock
// - I2S 256 kHz at 8k, 512 at 16k
// - I2S frame sync is word select
// - I2S clock phases within 45-55 percent
// - Audio pads blocked for other functions
module digital_audio_master_port #(
  parameter FIFO_DEPTH = `DAI_FIFO_DEPTH,
  parameter FIFO_AW = 2,
  parameter NCO_W = `DAI_NCO_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  output wire bclk_o,
  output wire fsync_o,
  output wire mclk_o,
  output wire sleep_ok_o,
  output wire pad_audio_o,
  input wire pad20_i,
  output wire pad20_o,
  output wire pad20_oe_n_o,
  input wire pad21_i,
  output wire pad21_o,
  output wire pad21_oe_n_o,
  input wire [1:0] gpio_o_i,
  input wire [1:0] gpio_oe_i,
  output wire [1:0] gpio_in_o
);
  localparam WB = `DAI_WORD_BITS;

  // Oscillator step for a bit clock of khz, two toggles per period
  function [NCO_W-1:0] nco_step;
    input [63:0] khz;
    reg [63:0] t;
    begin
      t = (khz * 64'd2000) << NCO_W;
      t = t / `DAI_CLK_HZ;
      nco_step = t[NCO_W-1:0];
    end
  endfunction

  // Register state
  reg [`DAI_C_W-1:0] ctrl_reg; // Control word
  reg ack_reg; // Bus acknowledge
  reg [31:0] dat_reg; // Bus read data
  reg [WB-1:0] rx_word_reg; // Last received sample
  reg rx_valid_reg; // New sample waiting
  reg undr_reg; // Frame started with empty buffer
  reg sleep_reg; // Sleep permission
  // Pad synchronisers
  reg [1:0] pad_s1_reg; // First stage, read by second only
  reg [1:0] pad_s2_reg; // Second stage
  // Serial engine
  reg run_reg; // Bit clock running
  reg [NCO_W-1:0] acc_reg; // Phase accumulator
  reg bclk_reg; // Bit clock output
  reg fsync_reg; // Frame sync / word select
  reg mclk_reg; // Master clock output
  reg [7:0] bit_reg; // Bit index now on the bus
  reg [WB-1:0] sh_reg; // Transmit shifter
  reg [WB-1:0] cur_reg; // Word of the current frame
  reg [WB-1:0] rsh_reg; // Receive shifter
  // Pad outputs
  reg pad20_reg;
  reg pad20_oe_n_reg;
  reg pad21_reg;
  reg pad21_oe_n_reg;
  reg [1:0] gpio_in_reg;

  // Control fields
  wire en = ctrl_reg[`DAI_C_EN];
  wire fmt_i2s = ctrl_reg[`DAI_C_FMT];
  wire fs8 = ctrl_reg[`DAI_C_RATE];
  wire [2:0] bsel = ctrl_reg[`DAI_C_BSEL_HI:`DAI_C_BSEL_LO];
  wire clk_cont = ~ctrl_reg[`DAI_C_CLKMODE];
  wire mclk_en = ctrl_reg[`DAI_C_MCLK];
  wire audio = ctrl_reg[`DAI_C_PAD];

  // Buffer wires
  wire fifo_in_ready;
  wire fifo_valid;
  wire [WB-1:0] fifo_data;
  wire pop;

  // Decoded configuration
  reg [2:0] bsel_eff;
  reg cfg_ok;
  reg [63:0] fkhz;
  reg [63:0] bits_full;
  reg [7:0] bits_m1;
  reg [NCO_W-1:0] step;

  // Bit clock choice and frame length
  always @* begin
    bsel_eff = bsel;
    cfg_ok = 1'b0;
    if (fmt_i2s) begin
      // Fixed clock per sample rate
      bsel_eff = fs8 ? `DAI_B256 : `DAI_B512;
      cfg_ok = 1'b1;
    end else if (fs8) begin
      cfg_ok = (bsel == `DAI_B256) | (bsel == `DAI_B512)
               | (bsel == `DAI_B2048);
    end else begin
      cfg_ok = (bsel == `DAI_B256) | (bsel == `DAI_B512)
               | (bsel == `DAI_B1024) | (bsel == `DAI_B4096);
    end
    // Pads must be handed to audio first
    cfg_ok = cfg_ok & audio;
    case (bsel_eff)
      `DAI_B256: fkhz = `DAI_F256_KHZ;
      `DAI_B512: fkhz = `DAI_F512_KHZ;
      `DAI_B1024: fkhz = `DAI_F1024_KHZ;
      `DAI_B2048: fkhz = `DAI_F2048_KHZ;
      `DAI_B4096: fkhz = `DAI_F4096_KHZ;
      default: fkhz = `DAI_F256_KHZ;
    endcase
    // Frame rate is the sample rate alone, never the call bandwidth
    bits_full = fs8 ? fkhz / `DAI_FS8_KHZ
                : fkhz / `DAI_FS16_KHZ;
    bits_full = bits_full - 64'd1;
    bits_m1 = bits_full[7:0];
    step = nco_step(fkhz);
  end

  // Bit clock event decode
  wire [NCO_W:0] acc_sum = {1'b0, acc_reg} + {1'b0, step};
  wire tick = run_reg & acc_sum[NCO_W];
  wire rise = tick & ~bclk_reg;
  wire fall = tick & bclk_reg;
  // I2S drives on falling edge, PCM on rising
  wire tx_ev = fmt_i2s ? fall : rise;
  wire rx_ev = fmt_i2s ? rise : fall;
  wire [7:0] nidx = (bit_reg == bits_m1) ? 8'h00 : bit_reg + 8'h01;
  wire [7:0] half = {1'b0, bits_m1[7:1]} + 8'h01;
  wire active = en & cfg_ok;
  wire start = ~run_reg & active & (clk_cont | fifo_valid);
  // Burst mode parks the clock low after a frame with nothing queued
  wire park = fall & ~clk_cont & ~fifo_valid & (bit_reg == bits_m1);

  // Transmit word selection
  wire [WB-1:0] head = fifo_valid ? fifo_data : {WB{1'b0}};
  wire ld_pcm = ~fmt_i2s & (nidx == 8'h00);
  wire ld_i2s = fmt_i2s & ((nidx == 8'h01) | (nidx == half + 8'h01));
  reg [WB-1:0] src;
  reg dout_nx;
  reg [WB-1:0] sh_nx;

  // Next data bit, MSB first
  always @* begin
    src = ld_pcm ? head : cur_reg;
    if (ld_pcm | ld_i2s) begin
      dout_nx = src[WB-1];
      sh_nx = {src[WB-2:0], 1'b0};
    end else begin
      dout_nx = sh_reg[WB-1];
      sh_nx = {sh_reg[WB-2:0], 1'b0};
    end
  end

  assign pop = tx_ev & (nidx == 8'h00) & ~park;

  // Receive window
  wire rx_cap = fmt_i2s ? ((bit_reg != 8'h00) & (bit_reg <= WB))
                : (bit_reg < WB);
  wire rx_done = fmt_i2s ? (bit_reg == WB) : (bit_reg == WB - 1);
  wire din = pad_s2_reg[1];

  // Bus decode
  wire req = cyc_i & stb_i & ~ack_reg;
  wire is_txd = (adr_i == `DAI_TXD_ADR);
  wire stall = we_i & is_txd & ~fifo_in_ready;
  wire acc_ok = req & ~stall;
  wire wr = acc_ok & we_i;
  wire rd = acc_ok & ~we_i;
  wire push = wr & is_txd;
  wire rx_set = run_reg & rx_ev & rx_cap & rx_done;
  wire rx_clr = rd & (adr_i == `DAI_RXD_ADR);
  wire undr_set = pop & ~fifo_valid;
  wire undr_clr = wr & (adr_i == `DAI_STAT_ADR) & sel_i[0]
                  & dat_i[`DAI_S_UNDR];
  reg [31:0] rdata;

  // Read data mux
  always @* begin
    rdata = 32'h0000_0000;
    case (adr_i)
      `DAI_CTRL_ADR: rdata[`DAI_C_W-1:0] = ctrl_reg;
      `DAI_STAT_ADR: begin
        rdata[`DAI_S_TXRDY] = fifo_in_ready;
        rdata[`DAI_S_RXV] = rx_valid_reg;
        rdata[`DAI_S_UNDR] = undr_reg;
        rdata[`DAI_S_CERR] = en & ~cfg_ok;
        rdata[`DAI_S_RUN] = run_reg;
        rdata[`DAI_S_SLEEP] = sleep_reg;
      end
      `DAI_RXD_ADR: rdata[WB-1:0] = rx_word_reg;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave and control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DAI_CTRL_RST;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc_ok;
      if (rd) begin
        dat_reg <= rdata;
      end
      // Control write by byte lane
      if (wr & (adr_i == `DAI_CTRL_ADR)) begin
        if (sel_i[0]) begin
          ctrl_reg[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          ctrl_reg[`DAI_C_PAD] <= dat_i[`DAI_C_PAD];
        end
      end
    end
  end

  // Sticky flags, set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_reg <= 1'b0;
      undr_reg <= 1'b0;
      sleep_reg <= 1'b1;
    end else begin
      if (rx_set) begin
        rx_valid_reg <= 1'b1;
      end else if (rx_clr) begin
        rx_valid_reg <= 1'b0;
      end
      if (undr_set) begin
        undr_reg <= 1'b1;
      end else if (undr_clr) begin
        undr_reg <= 1'b0;
      end
      // Continuous clock keeps the device awake
      sleep_reg <= ~(en & clk_cont);
    end
  end

  // Pad input synchronisers
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_s1_reg <= 2'h0;
      pad_s2_reg <= 2'h0;
    end else begin
      pad_s1_reg <= {pad21_i, pad20_i};
      pad_s2_reg <= pad_s1_reg;
    end
  end

  // Bit clock, frame sync and shifters
  always @(posedge clk_i) begin
    if (rst_i | ~active) begin
      // Idle: everything low, input ignored
      run_reg <= 1'b0;
      acc_reg <= {NCO_W{1'b0}};
      bclk_reg <= 1'b0;
      fsync_reg <= 1'b0;
      mclk_reg <= 1'b0;
      bit_reg <= 8'h00;
      sh_reg <= {WB{1'b0}};
      cur_reg <= {WB{1'b0}};
      rsh_reg <= {WB{1'b0}};
    end else if (start) begin
      // First transmit event opens bit 0
      run_reg <= 1'b1;
      acc_reg <= {NCO_W{1'b0}};
      bit_reg <= bits_m1;
    end else if (run_reg) begin
      // Toggling at an accumulator carry keeps phases near half
      acc_reg <= acc_sum[NCO_W-1:0];
      if (tick) begin
        bclk_reg <= ~bclk_reg;
      end
      mclk_reg <= mclk_en & (tick ? ~bclk_reg : bclk_reg);
      if (park) begin
        run_reg <= 1'b0;
        mclk_reg <= 1'b0;
      end else if (tx_ev) begin
        bit_reg <= nidx;
        sh_reg <= sh_nx;
        if (fmt_i2s) begin
          fsync_reg <= (nidx >= half);
        end else begin
          fsync_reg <= (nidx < WB);
        end
        if (pop) begin
          cur_reg <= head;
        end
      end
      if (rx_ev & rx_cap) begin
        rsh_reg <= {rsh_reg[WB-2:0], din};
      end
    end
  end

  // Received word, left channel in I2S
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_word_reg <= {WB{1'b0}};
    end else if (rx_set) begin
      rx_word_reg <= {rsh_reg[WB-2:0], din};
    end
  end

  // Pad multiplexing, audio locks out the general-purpose path
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad20_reg <= 1'b0;
      pad20_oe_n_reg <= 1'b1;
      pad21_reg <= 1'b0;
      pad21_oe_n_reg <= 1'b1;
      gpio_in_reg <= 2'h0;
    end else if (audio) begin
      // Data out driven, data in listened to only
      if (~active) begin
        pad20_reg <= 1'b0;
      end else if (run_reg & tx_ev & ~park) begin
        pad20_reg <= dout_nx;
      end
      pad20_oe_n_reg <= 1'b0;
      pad21_reg <= 1'b0;
      pad21_oe_n_reg <= 1'b1;
      gpio_in_reg <= 2'h0;
    end else begin
      pad20_reg <= gpio_o_i[0];
      pad20_oe_n_reg <= ~gpio_oe_i[0];
      pad21_reg <= gpio_o_i[1];
      pad21_oe_n_reg <= ~gpio_oe_i[1];
      gpio_in_reg <= pad_s2_reg;
    end
  end

  // Sample buffer toward the serial side
  sample_fifo #(
    .WIDTH(WB),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_data_i(dat_i[WB-1:0]),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(pop)
  );

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign bclk_o = bclk_reg;
  assign fsync_o = fsync_reg;
  assign mclk_o = mclk_reg;
  assign sleep_ok_o = sleep_reg;
  assign pad_audio_o = audio;
  assign pad20_o = pad20_reg;
  assign pad20_oe_n_o = pad20_oe_n_reg;
  assign pad21_o = pad21_reg;
  assign pad21_oe_n_o = pad21_oe_n_reg;
  assign gpio_in_o = gpio_in_reg;
endmodule // digital_audio_master_port

/* File: bench/dai_port_chk.sv */
`timescale 1ns/1ps
// Watches the pad, clock and frame outputs of the audio port
module dai_port_chk (
  input wire clk_i,
  input wire rst_i,
  input wire bclk_o,
  input wire fsync_o,
  input wire mclk_o,
  input wire sleep_ok_o,
  input wire pad_audio_o,
  input wire pad20_o,
  input wire pad20_oe_n_o,
  input wire pad21_oe_n_o,
  input wire [1:0] gpio_o_i,
  input wire [1:0] gpio_oe_i,
  input wire [1:0] gpio_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_mclk_rise:
    assert property ($rose(mclk_o) |-> $rose(bclk_o))
    else $error("master clock rose without bit clock");
  chk_mclk_fall:
    assert property ($fell(mclk_o) |-> $fell(bclk_o))
    else $error("master clock fell without bit clock");
  chk_pads_audio:
    assert property (pad_audio_o && $past(pad_audio_o) |->
      !pad20_oe_n_o && pad21_oe_n_o && gpio_in_o == 2'h0)
    else $error("audio pads still open to other use");
  chk_pads_gpio:
    assert property (!pad_audio_o && !$past(pad_audio_o) |->
      pad20_o == $past(gpio_o_i[0]) && pad20_oe_n_o == !$past(gpio_oe_i[0]))
    else $error("pad 20 does not follow its general request");
  chk_idle_low:
    assert property (!pad_audio_o && !$past(pad_audio_o)
      && !$past(pad_audio_o, 2) |-> !bclk_o && !fsync_o && !mclk_o)
    else $error("inactive port drives a clock or sync");
  chk_nosleep_clk:
    assert property (!sleep_ok_o && pad_audio_o |->
      ##[0:40] ($changed(bclk_o) || sleep_ok_o || !pad_audio_o))
    else $error("sleep barred but bit clock stands");
  chk_sync_edge:
    assert property (pad_audio_o && $changed(fsync_o) |-> $changed(bclk_o))
    else $error("frame sync moved off a bit clock edge");
  chk_data_edge:
    assert property (pad_audio_o && $past(pad_audio_o) && $changed(pad20_o)
      |-> $changed(bclk_o))
    else $error("data out moved off a bit clock edge");
endmodule // dai_port_chk

bind digital_audio_master_port dai_port_chk dai_port_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .bclk_o(bclk_o), .fsync_o(fsync_o),
  .mclk_o(mclk_o), .sleep_ok_o(sleep_ok_o), .pad_audio_o(pad_audio_o),
  .pad20_o(pad20_o), .pad20_oe_n_o(pad20_oe_n_o),
  .pad21_oe_n_o(pad21_oe_n_o), .gpio_o_i(gpio_o_i), .gpio_oe_i(gpio_oe_i),
  .gpio_in_o(gpio_in_o));

/* File: bench/codec_model.sv */
`timescale 1ns/1ps
// Far-side codec: sends one fixed word a frame, collects words heard
module codec_model #(
  parameter [15:0] TX_WORD = 16'h5A3C
) (
  input wire bclk_i,
  input wire fsync_i,
  input wire dout_i,
  output reg din_o,
  output reg [15:0] rx_word_o,
  output reg [31:0] rx_cnt_o
);
  integer tx_idx = 99; // Bit position being sent
  integer rx_idx = 99; // Bit position being heard
  reg fs_tx = 1'b0;
  reg fs_rx = 1'b0;
  reg [15:0] shift = 16'h0;
  initial begin
    din_o = 1'b0;
    rx_word_o = 16'h0;
    rx_cnt_o = 32'h0;
  end
  // Drive just after each rise, MSB first, then a toggling line
  always @(posedge bclk_i) begin
    #1;
    // Sync held high across a 16-bit frame marks back-to-back frames
    tx_idx = (fsync_i && (!fs_tx || tx_idx == 15)) ? 0 : tx_idx + 1;
    fs_tx = fsync_i;
    din_o = (tx_idx < 16) ? TX_WORD[15 - tx_idx] : ~din_o;
  end
  // Sample on falling edges, sixteen bits a word
  always @(negedge bclk_i) begin
    rx_idx = (fsync_i && (!fs_rx || rx_idx == 15)) ? 0 : rx_idx + 1;
    fs_rx = fsync_i;
    if (rx_idx < 16) shift = {shift[14:0], dout_i};
    if (rx_idx == 15) begin
      rx_word_o = shift;
      rx_cnt_o = rx_cnt_o + 32'h1;
    end
  end
endmodule // codec_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "dai_defines.vh"
// Self-checking bench for the audio port
module testbench;
  reg clk_i, rst_i, cyc_i, stb_i, we_i;
  reg [7:0] adr_i;
  reg [3:0] sel_i;
  reg [31:0] dat_i, rd;
  reg [1:0] gpio_o_i, gpio_oe_i;
  wire [31:0] dat_o, rx_cnt;
  wire [15:0] rx_word;
  wire [1:0] gpio_in_o;
  wire ack_o, bclk_o, fsync_o, mclk_o, sleep_ok_o, pad_audio_o, din;
  wire pad20_o, pad20_oe_n_o, pad21_o, pad21_oe_n_o;
  integer err_count, compares, i, n0;
  // Pad 20 pulled down when released; pad 21 codec-driven when released
  wire pad20_w = pad20_oe_n_o ? 1'b0 : pad20_o;
  wire pad21_w = pad21_oe_n_o ? din : pad21_o;
  digital_audio_master_port digital_audio_master_port_i (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bclk_o(bclk_o), .fsync_o(fsync_o), .mclk_o(mclk_o),
    .sleep_ok_o(sleep_ok_o), .pad_audio_o(pad_audio_o), .pad20_i(pad20_w),
    .pad20_o(pad20_o), .pad20_oe_n_o(pad20_oe_n_o), .pad21_i(pad21_w),
    .pad21_o(pad21_o), .pad21_oe_n_o(pad21_oe_n_o), .gpio_o_i(gpio_o_i),
    .gpio_oe_i(gpio_oe_i), .gpio_in_o(gpio_in_o));
  codec_model codec_model_i (.bclk_i(bclk_o), .fsync_i(fsync_o),
    .dout_i(pad20_w), .din_o(din), .rx_word_o(rx_word), .rx_cnt_o(rx_cnt));
  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Compare and count
  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // One classic bus cycle; read data lands in rd
  task acc(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 3000) begin
        @(posedge clk_i);
        n = n + 1;
      end
      // A bus that never answers counts as a mismatch
      if (ack_o !== 1'b1) err_count = err_count + 1;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Wait until the codec has heard n words
  task wait_rx(input [31:0] n);
    integer k;
    begin
      k = 0;
      while (rx_cnt < n && k < 3000) begin
        @(posedge clk_i);
        k = k + 1;
      end
      if (rx_cnt < n) err_count = err_count + 1;
    end
  endtask
  // Sample word number i
  function [15:0] wd(input integer i);
    wd = 16'h8001 + i * 16'h1111;
  endfunction
  // Reset state, unmapped access
  task t_reset;
    begin
      check(bclk_o | fsync_o | mclk_o | pad20_o, 0);
      check(pad20_oe_n_o & sleep_ok_o, 1);
      acc(8'h20, 1'b1, 32'hFFFFFFFF);
      acc(8'h20, 1'b0, 32'h0);
      check(rd, 0);
      acc(`DAI_CTRL_ADR, 1'b0, 32'h0);
      check(rd, `DAI_CTRL_RST);
      $display("reset test done");
    end
  endtask
  // Pads as general I/O, then claimed for audio
  task t_gpio;
    begin
      gpio_o_i <= 2'h2;
      gpio_oe_i <= 2'h2;
      repeat (5) @(posedge clk_i);
      check({pad20_oe_n_o, gpio_in_o}, 3'h6);
      gpio_o_i <= 2'h3;
      gpio_oe_i <= 2'h3;
      repeat (5) @(posedge clk_i);
      check({pad20_o, gpio_in_o}, 3'h7);
      gpio_o_i <= 2'h0;
      acc(`DAI_CTRL_ADR, 1'b1, 32'h100);
      repeat (5) @(posedge clk_i);
      check({pad20_oe_n_o, pad21_oe_n_o, pad20_o, gpio_in_o}, 5'h8);
      acc(`DAI_CTRL_ADR, 1'b1, 32'h0);
      $display("pad test done");
    end
  endtask
  // Fill buffer, stall a write, stream words, underrun
  task t_stream;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        acc(`DAI_TXD_ADR, 1'b1, {16'h0, wd(i)});
        acc(`DAI_STAT_ADR, 1'b0, 32'h0);
        check(rd[`DAI_S_TXRDY], i < 3);
      end
      n0 = rx_cnt;
      acc(`DAI_CTRL_ADR, 1'b1, 32'h101);
      acc(`DAI_TXD_ADR, 1'b1, {16'h0, wd(4)});
      for (i = 0; i < 6; i = i + 1) begin
        wait_rx(n0 + i + 1);
        check(rx_word, i < 5 ? wd(i) : 16'h0);
      end
      check(sleep_ok_o, 0);
      acc(`DAI_STAT_ADR, 1'b0, 32'h0);
      check(rd[`DAI_S_UNDR] & rd[`DAI_S_RXV], 1);
      acc(`DAI_RXD_ADR, 1'b0, 32'h0);
      check(rd[15:0], 16'h5A3C);
      acc(`DAI_CTRL_ADR, 1'b1, 32'h0);
      repeat (3) @(posedge clk_i);
      check(bclk_o | fsync_o | pad20_o, 0);
      $display("stream test done");
    end
  endtask
  // Illegal clock choice, then burst clocking
  task t_burst;
    begin
      acc(`DAI_CTRL_ADR, 1'b1, 32'h155);
      repeat (50) @(posedge clk_i);
      acc(`DAI_STAT_ADR, 1'b0, 32'h0);
      check({rd[`DAI_S_CERR], rd[`DAI_S_RUN], bclk_o}, 3'h4);
      acc(`DAI_CTRL_ADR, 1'b1, 32'h141);
      repeat (50) @(posedge clk_i);
      check({sleep_ok_o, bclk_o}, 2'h2);
      n0 = rx_cnt;
      acc(`DAI_TXD_ADR, 1'b1, 32'h1234);
      wait_rx(n0 + 1);
      check(rx_word, 16'h1234);
      repeat (700) @(posedge clk_i);
      check(bclk_o, 0);
      acc(`DAI_CTRL_ADR, 1'b1, 32'h0);
      $display("burst test done");
    end
  endtask
  // Run one setting; count bits, sync, master clock, high time
  task measure(input [31:0] c, input integer bits, per, hmin);
    integer k, fs, br, mr, fr, hr, hlo, hhi;
    reg pb, pf, pm;
    begin
      acc(`DAI_CTRL_ADR, 1'b1, c);
      {fs, k, br, mr, fr, hr, hlo, hhi} = {32'd0, 32'd0, 32'd0, 32'd0,
        32'd0, 32'd0, 32'd999, 32'd0};
      {pb, pf, pm} = 3'h0;
      while (fs < 3 && k < 9000) begin
        @(posedge clk_i);
        // Sync rise, or a full frame of bits under a standing sync
        if (fsync_o && (!pf || (bclk_o && !pb && br == bits))) begin
          fs = fs + 1;
          if (fs < 3) {k, br, mr, fr} = 128'h0;
        end
        if (fs < 3) begin
          k = k + 1;
          if (bclk_o && !pb) br = br + 1;
          if (bclk_o && !pb && fsync_o) fr = fr + 1;
          if (mclk_o && !pm) mr = mr + 1;
          if (bclk_o) hr = hr + 1;
          else begin
            if (pb && fs == 2) hlo = hr < hlo ? hr : hlo;
            if (pb && fs == 2) hhi = hr > hhi ? hr : hhi;
            hr = 0;
          end
        end
        {pb, pf, pm} = {bclk_o, fsync_o, mclk_o};
      end
      check(k >= per - 1 && k <= per + 1 && fs == 3, 1);
      check(br, bits);
      check(fr, 16);
      check(mr, c[7] ? bits : 0);
      if (hmin > 0) check(hlo >= hmin && hhi <= hmin + 1, 1);
      acc(`DAI_CTRL_ADR, 1'b1, 32'h0);
    end
  endtask
  // Every bit clock choice of both formats
  task t_rates;
    begin
      measure(32'h101, 16, 625, 0);
      measure(32'h189, 32, 625, 0);
      measure(32'h111, 64, 625, 0);
      measure(32'h1A1, 256, 625, 0);
      measure(32'h105, 32, 1250, 0);
      measure(32'h18D, 64, 1250, 0);
      measure(32'h11D, 256, 1250, 0);
      measure(32'h183, 32, 625, 9);
      measure(32'h107, 32, 1250, 19);
      $display("rate test done");
    end
  endtask
  // Print counts and verdict, end run
  task conclude;
    begin
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    {rst_i, cyc_i, stb_i, we_i} <= 4'h8;
    {adr_i, sel_i, dat_i} <= {8'h0, 4'hF, 32'h0};
    {gpio_o_i, gpio_oe_i} <= 4'h0;
    {err_count, compares} = 64'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_gpio;
    t_stream;
    t_burst;
    t_rates;
    conclude;
  end
  // Watchdog, about three and a half times the expected run
  initial begin
    #8000000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // testbench
